// >>> canil_interrupt_logic.sv
// Interrupt flags, enables, error status and interrupt output of the CAN controller.
`timescale 1ns/1ps
module canil_interrupt_logic (
    input wire logic sys_clk, // System clock, 25 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic regWrEn, // Full register write strobe.
    input wire logic regModEn, // Masked bit-modify write strobe.
    input wire logic regRdEn, // Register read strobe.
    input wire logic [7:0] regAddr, // Register address.
    input wire logic [7:0] regWrData, // Write data.
    input wire logic [7:0] regWrMask, // Bit-modify mask.
    input wire logic msgErrorEvt, // Pulse: error seen during a frame.
    input wire logic sleeping, // Level: device is in sleep mode.
    input wire logic busActivity, // Level: activity on the bus receive line.
    input wire logic [1:0] rxFrameAccepted, // Pulse per buffer: filtered frame ready.
    input wire logic [2:0] txBufEmptyEvt, // Pulse per buffer: transmit buffer emptied.
    input wire logic [7:0] rxErrCount, // Receive error count.
    input wire logic [8:0] txErrCount, // Transmit error count.
    input wire logic busRecovered, // Pulse: bus-off recovery finished.
    output logic [7:0] regRdData, // Read data, registered.
    output logic intN, // Interrupt output, active low.
    output logic [2:0] pendingSourceCode, // Highest priority pending source.
    output logic wakeReq, // Pulse: leave sleep.
    output logic [7:0] errorStatus, // Error status register contents.
    output logic [1:0] rxBufFull // Receive buffer occupied flags.
);

    // Stored enable bits.
    logic [7:0] irqEnable_reg;
    // Stored flag bits.
    logic [7:0] irqFlags_reg;
    // Stored error status bits.
    logic [7:0] errStatus_reg;
    // Registered outputs.
    logic intN_reg;
    logic [2:0] code_reg;
    logic wakeReq_reg;
    logic [7:0] rdData_reg;
    // Next values.
    logic [7:0] irqEnable_next;
    logic [7:0] irqFlags_next;
    logic [7:0] errStatus_next;
    logic [2:0] code_next;
    // Hardware set requests and host-written value of the flags.
    logic [7:0] flagSet;
    logic [7:0] hostFlags;
    logic [7:0] stHost; // Host-written value of the error status.
    // Decoded write strobes.
    logic enWrite;
    logic flWrite;
    logic stWrite;
    // Wake event and receive overflow events.
    logic wakeEvt;
    logic [1:0] rxStore;
    logic [1:0] rxOverflow;
    logic errChange;
    // Enabled pending sources.
    logic [7:0] pendingEn;

    // Address decode of host writes; bit-modify counts as a write too.
    assign enWrite = (regWrEn | regModEn) && regAddr == canil_pkg::IRQ_ENABLE_ADDR;
    assign flWrite = (regWrEn | regModEn) && regAddr == canil_pkg::IRQ_FLAGS_ADDR;
    assign stWrite = (regWrEn | regModEn) && regAddr == canil_pkg::ERR_STATUS_ADDR;

    // Merge a host write with the old value; bit-modify touches masked bits only.
    // Every input is an argument, so a continuous assignment re-evaluates on any of them.
    function automatic logic [7:0] apply(input logic [7:0] old, input logic modify,
        input logic [7:0] data, input logic [7:0] mask);
        logic [7:0] res;
        res = modify ? ((old & ~mask) | (data & mask)) : data;
        return res;
    endfunction

    // Enable register next value.
    always_comb begin
        irqEnable_next = enWrite ? apply(irqEnable_reg, regModEn, regWrData, regWrMask)
            : irqEnable_reg;
    end

    // Enable register storage, reset to zero.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqEnable_reg <= canil_pkg::IRQ_ENABLE_RST;
        end else begin
            irqEnable_reg <= irqEnable_next;
        end
    end

    // Wake only counts while asleep with the wake enable at one.
    assign wakeEvt = sleeping & busActivity & irqEnable_reg[canil_pkg::BIT_WAKE];

    // A frame is stored when its buffer is free, otherwise it overflows.
    assign rxStore = rxFrameAccepted & ~irqFlags_reg[1:0];
    assign rxOverflow = rxFrameAccepted & irqFlags_reg[1:0];

    // Host-written value of the error status; only its overflow bits are used.
    assign stHost = apply(errStatus_reg, regModEn, regWrData, regWrMask);

    // Error status next value: counters compared live, sticky bits held.
    always_comb begin
        errStatus_next = errStatus_reg;
        if (stWrite) begin
            // Only the overflow bits may be cleared by the host; writing one keeps them.
            errStatus_next[7:6] = errStatus_reg[7:6] & stHost[7:6];
        end
        // Set wins over a clear in the same cycle.
        errStatus_next[canil_pkg::ST_RX1_OVR] = errStatus_next[7] | rxOverflow[1];
        errStatus_next[canil_pkg::ST_RX0_OVR] = errStatus_next[6] | rxOverflow[0];
        errStatus_next[canil_pkg::ST_RX_WARN] = {1'b0, rxErrCount} >= canil_pkg::WARN_LIMIT;
        errStatus_next[canil_pkg::ST_TX_WARN] = txErrCount >= canil_pkg::WARN_LIMIT;
        errStatus_next[canil_pkg::ST_RX_PASS] = {1'b0, rxErrCount} > canil_pkg::PASSIVE_LIMIT;
        errStatus_next[canil_pkg::ST_TX_PASS] = txErrCount > canil_pkg::PASSIVE_LIMIT;
        errStatus_next[canil_pkg::ST_ANY_WARN] = errStatus_next[1] | errStatus_next[2];
        // Bus-off is sticky: a count above the limit keeps it set, and only a
        // finished recovery with the count back in range clears it.
        if (txErrCount > canil_pkg::BUS_OFF_LIMIT) begin
            errStatus_next[canil_pkg::ST_BUS_OFF] = 1'b1;
        end else if (busRecovered) begin
            errStatus_next[canil_pkg::ST_BUS_OFF] = 1'b0;
        end
    end

    // Error status storage.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            errStatus_reg <= canil_pkg::ERR_STATUS_RST;
        end else begin
            errStatus_reg <= errStatus_next;
        end
    end

    // An error flag event is an overflow or any change of error state.
    // Clearing an overflow bit is not a change of state and raises nothing.
    assign errChange = (|rxOverflow) | (|(errStatus_next[5:0] ^ errStatus_reg[5:0]));

    // Hardware set requests, in flag bit order.
    always_comb begin
        flagSet = 8'h00;
        flagSet[canil_pkg::BIT_MSG_ERR] = msgErrorEvt;
        flagSet[canil_pkg::BIT_WAKE] = wakeEvt;
        flagSet[canil_pkg::BIT_ERR] = errChange;
        flagSet[canil_pkg::BIT_TX0 +: 3] = txBufEmptyEvt;
        flagSet[canil_pkg::BIT_RX0 +: 2] = rxStore;
    end

    // Value the host leaves in the flags, including host-set bits.
    assign hostFlags = flWrite ? apply(irqFlags_reg, regModEn, regWrData, regWrMask)
        : irqFlags_reg;

    // Per-bit flag update; a live cause overrides a host clear.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : gFlag
            always_comb begin
                irqFlags_next[gi] = hostFlags[gi] | flagSet[gi];
            end
        end
    endgenerate

    // Flag register storage.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqFlags_reg <= canil_pkg::IRQ_FLAGS_RST;
        end else begin
            irqFlags_reg <= irqFlags_next;
        end
    end

    // Enabled pending sources.
    assign pendingEn = irqFlags_next & irqEnable_next;

    // Priority encoder: error first, then wake, transmit 0..2, receive 0..1.
    // Message error has no code of its own; it only pulls the pin low.
    always_comb begin
        if (pendingEn[canil_pkg::BIT_ERR]) begin
            code_next = canil_pkg::CODE_ERR;
        end else if (pendingEn[canil_pkg::BIT_WAKE]) begin
            code_next = canil_pkg::CODE_WAKE;
        end else if (pendingEn[2]) begin
            code_next = canil_pkg::CODE_TX0;
        end else if (pendingEn[3]) begin
            code_next = canil_pkg::CODE_TX1;
        end else if (pendingEn[4]) begin
            code_next = canil_pkg::CODE_TX2;
        end else if (pendingEn[0]) begin
            code_next = canil_pkg::CODE_RX0;
        end else if (pendingEn[1]) begin
            code_next = canil_pkg::CODE_RX1;
        end else begin
            code_next = canil_pkg::CODE_NONE;
        end
    end

    // Interrupt pin and source code, updated every cycle.
    // Post-update flags let the pin follow a host clear on the same edge.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            intN_reg <= 1'b1;
            code_reg <= canil_pkg::CODE_NONE;
        end else begin
            intN_reg <= ~(|pendingEn);
            code_reg <= code_next;
        end
    end

    // Wake request pulse tells sleep control to leave sleep.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wakeReq_reg <= 1'b0;
        end else begin
            wakeReq_reg <= wakeEvt;
        end
    end

    // Registered read port; unmapped addresses read zero.
    // A read sees register contents from before this edge's updates.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData_reg <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                canil_pkg::IRQ_ENABLE_ADDR: rdData_reg <= irqEnable_reg;
                canil_pkg::IRQ_FLAGS_ADDR: rdData_reg <= irqFlags_reg;
                canil_pkg::ERR_STATUS_ADDR: rdData_reg <= errStatus_reg;
                default: rdData_reg <= 8'h00;
            endcase
        end
    end

    // Outputs straight from flip-flops.
    assign intN = intN_reg;
    assign pendingSourceCode = code_reg;
    assign wakeReq = wakeReq_reg;
    assign regRdData = rdData_reg;
    assign errorStatus = errStatus_reg;
    assign rxBufFull = irqFlags_reg[1:0];

    // Checks run on the system clock and pause during reset.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // A frame error sets the message error flag next cycle.
    a_msg_err_set: assert property (msgErrorEvt |=> irqFlags_reg[7])
        else $error("Message error flag not set.");
    // Wake while asleep and enabled sets flag and requests exit.
    a_wake_set: assert property (wakeEvt |=> irqFlags_reg[6] && wakeReq)
        else $error("Wake event lost.");
    // Wake flag stays clear when wake is disabled and host does not write.
    a_wake_gate: assert property ((!irqEnable_reg[6] && !flWrite && !irqFlags_reg[6])
        |=> !irqFlags_reg[6])
        else $error("Wake flag set while disabled.");
    // Overflow bit set when a full buffer gets a frame.
    a_ovr_set: assert property (rxOverflow[0] |=> errStatus_reg[6] && irqFlags_reg[5])
        else $error("Overflow not recorded.");
    // Warning, passive and bus-off thresholds track the counters.
    a_warn_rx: assert property (rxErrCount >= 8'h60 |=> errStatus_reg[1])
        else $error("Receive warning missing.");
    a_warn_tx: assert property (txErrCount < 9'h060 |=> !errStatus_reg[2])
        else $error("Transmit warning wrong.");
    a_pass_rx: assert property (rxErrCount == 8'h80 |=> errStatus_reg[3])
        else $error("Receive passive missing.");
    a_pass_tx: assert property (txErrCount == 9'h07F |=> !errStatus_reg[4])
        else $error("Transmit passive too early.");
    a_bus_off: assert property (txErrCount > 9'h0FF |=> errStatus_reg[5])
        else $error("Bus-off not reported.");
    // Interrupt low exactly when an enabled flag is pending.
    a_int_level: assert property (##1 (intN == !(|(irqFlags_reg & irqEnable_reg))))
        else $error("Interrupt pin mismatch.");
    // A clear during a live set leaves the flag set.
    a_set_wins: assert property ((flWrite && txBufEmptyEvt[0]) |=> irqFlags_reg[2])
        else $error("Set lost to clear.");
    // Host full write lands in the flags when no event is present.
    a_host_wr: assert property ((regWrEn && !regModEn && flWrite && flagSet == 8'h00)
        |=> irqFlags_reg == $past(regWrData))
        else $error("Host flag write lost.");
    // Source code is the error code whenever error is enabled and pending.
    a_code_err: assert property (##1 (irqFlags_reg[5] && irqEnable_reg[5])
        |-> pendingSourceCode == 3'h1)
        else $error("Source code priority wrong.");

    // A frame stored in a free buffer marks it full next cycle.
    a_rx_store: assert property (rxStore[0] |=> rxBufFull[0])
        else $error("Stored frame not flagged.");
    // An emptied transmit buffer two sets its own flag.
    a_tx_empty: assert property (txBufEmptyEvt[2] |=> irqFlags_reg[4])
        else $error("Transmit empty flag not set.");
    // An overflow bit holds until the host writes the status register.
    a_ovr_hold: assert property ((errStatus_reg[6] && !stWrite) |=> errStatus_reg[6])
        else $error("Overflow bit dropped.");
    // The wake request falls once the wake condition is gone.
    a_wake_drop: assert property (!wakeEvt |=> !wakeReq)
        else $error("Wake request without wake event.");
    // Any change of error state raises the error flag on the same edge.
    a_err_flag: assert property (($changed(errStatus_reg[5:0]) && !$past(sys_rst))
        |-> irqFlags_reg[5])
        else $error("Error state change not flagged.");

    // Main scenarios.
    c_wake: cover property (wakeEvt ##1 !intN);
    c_overflow: cover property (rxStore[0] ##[1:20] rxOverflow[0]);
    c_bitmod_clear: cover property (irqFlags_reg[0] ##1 regModEn && flWrite ##1 !irqFlags_reg[0]);
    c_bus_off: cover property (errStatus_reg[5] ##[1:20] busRecovered);
    c_host_set: cover property ((regWrEn && flWrite) ##1 !intN);

endmodule

// >>> canil_pkg.sv
// Package of constants for the CAN controller interrupt logic.
package canil_pkg;
    // Register offsets on the serial register port.
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h2B;
    localparam logic [7:0] IRQ_FLAGS_ADDR = 8'h2C;
    localparam logic [7:0] ERR_STATUS_ADDR = 8'h2D;
    // Reset values.
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
    localparam logic [7:0] ERR_STATUS_RST = 8'h00;
    // Bit positions shared by the enable and flag registers.
    localparam int BIT_MSG_ERR = 7;
    localparam int BIT_WAKE = 6;
    localparam int BIT_ERR = 5;
    localparam int BIT_TX0 = 2;
    localparam int BIT_RX0 = 0;
    // Bit positions in the error status register.
    localparam int ST_RX1_OVR = 7;
    localparam int ST_RX0_OVR = 6;
    localparam int ST_BUS_OFF = 5;
    localparam int ST_TX_PASS = 4;
    localparam int ST_RX_PASS = 3;
    localparam int ST_TX_WARN = 2;
    localparam int ST_RX_WARN = 1;
    localparam int ST_ANY_WARN = 0;
    // Error counter limits.
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;
    // Pending source codes, lower value wins.
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_ERR = 3'h1;
    localparam logic [2:0] CODE_WAKE = 3'h2;
    localparam logic [2:0] CODE_TX0 = 3'h3;
    localparam logic [2:0] CODE_TX1 = 3'h4;
    localparam logic [2:0] CODE_TX2 = 3'h5;
    localparam logic [2:0] CODE_RX0 = 3'h6;
    localparam logic [2:0] CODE_RX1 = 3'h7;
endpackage

// >>> canil_host_model.sv
// Host model reaching the interrupt registers over the register port.
`timescale 1ns/1ps
module canil_host_model (
    input wire logic sys_clk, // System clock.
    output logic regWrEn, // Full write strobe.
    output logic regModEn, // Bit-modify strobe.
    output logic regRdEn, // Read strobe.
    output logic [7:0] regAddr, // Register address.
    output logic [7:0] regWrData, // Write data.
    output logic [7:0] regWrMask, // Bit-modify mask.
    input wire logic [7:0] regRdData // Registered read data.
);
    // Strobes start idle so nothing is requested during reset.
    initial begin
        regWrEn = 1'b0;
        regModEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrMask = 8'h00;
    end
    // One access held from a falling edge across the taking rising edge.
    task automatic access(input logic [2:0] kind, input logic [7:0] a, d, m);
        @(negedge sys_clk);
        {regRdEn, regModEn, regWrEn} = kind;
        regAddr = a;
        regWrData = d;
        regWrMask = m;
        @(negedge sys_clk);
        {regRdEn, regModEn, regWrEn} = 3'h0;
        // Released lines flip so no stale value looks valid.
        regAddr = ~a;
        regWrData = ~d;
        regWrMask = ~m;
    endtask
    // Full write of one register.
    task automatic wr(input logic [7:0] a, d);
        access(3'h1, a, d, 8'h00);
    endtask
    // Masked clear of flags, the safe way to acknowledge.
    task automatic md(input logic [7:0] a, m, d);
        access(3'h2, a, d, m);
    endtask
    // Read; the data is taken one and a half cycles after the taking edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        access(3'h4, a, 8'h00, 8'h00);
        @(negedge sys_clk);
        d = regRdData;
    endtask
endmodule

// >>> test_canil_interrupt_logic.sv
// Self-checking testbench of the CAN controller interrupt logic.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module test_canil_interrupt_logic;
    logic sys_clk = 1'b0; // Clock.
    logic sys_rst = 1'b1; // Reset.
    logic regWrEn, regModEn, regRdEn; // Register strobes.
    logic [7:0] regAddr, regWrData, regWrMask, regRdData; // Register lines.
    logic msgErrorEvt = 1'b0, sleeping = 1'b0, busActivity = 1'b0; // Events.
    logic [1:0] rxFrameAccepted = 2'h0; // Receive frame pulses.
    logic [2:0] txBufEmptyEvt = 3'h0; // Transmit empty pulses.
    logic [7:0] rxErrCount = 8'h00; // Receive error count.
    logic [8:0] txErrCount = 9'h000; // Transmit error count.
    logic busRecovered = 1'b0; // Recovery pulse.
    logic intN, wakeReq; // Interrupt and wake outputs.
    logic [2:0] pendingSourceCode; // Pending source code.
    logic [7:0] errorStatus; // Error status.
    logic [1:0] rxBufFull; // Buffer full flags.
    int mismatches = 0, comparisons = 0, cycles = 0; // Counters.

    canil_interrupt_logic canil_interrupt_logic_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .regWrEn(regWrEn), .regModEn(regModEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrMask(regWrMask), .msgErrorEvt(msgErrorEvt),
        .sleeping(sleeping), .busActivity(busActivity), .rxFrameAccepted(rxFrameAccepted),
        .txBufEmptyEvt(txBufEmptyEvt), .rxErrCount(rxErrCount), .txErrCount(txErrCount),
        .busRecovered(busRecovered), .regRdData(regRdData), .intN(intN),
        .pendingSourceCode(pendingSourceCode), .wakeReq(wakeReq),
        .errorStatus(errorStatus), .rxBufFull(rxBufFull));
    canil_host_model canil_host_model_i (.sys_clk(sys_clk), .regWrEn(regWrEn),
        .regModEn(regModEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrMask(regWrMask), .regRdData(regRdData));

    // Clock of 40 ns period.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Cycle ceiling cuts a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Waits one falling edge.
    task automatic tick();
        @(negedge sys_clk);
    endtask
    // Reads a register and compares it.
    task automatic rdChk(input logic [7:0] a, exp);
        logic [7:0] d;
        canil_host_model_i.rd(a, d);
        `CHK(d, exp)
    endtask
    // Reset values and enable register access, unmapped read.
    task automatic testRegs();
        `CHK(intN, 1'b1)
        rdChk(8'h2B, 8'h00);
        rdChk(8'h2C, 8'h00);
        canil_host_model_i.wr(8'h2B, 8'hA5);
        rdChk(8'h2B, 8'hA5);
        rdChk(8'h30, 8'h00);
        canil_host_model_i.wr(8'h2B, 8'h00);
    endtask
    // Message error sets its flag and holds the interrupt until cleared.
    task automatic testMsgErr();
        canil_host_model_i.wr(8'h2B, 8'h80);
        msgErrorEvt = 1'b1;
        tick();
        msgErrorEvt = 1'b0;
        tick();
        `CHK(intN, 1'b0)
        rdChk(8'h2C, 8'h80);
        `CHK(intN, 1'b0)
        canil_host_model_i.md(8'h2C, 8'h80, 8'h00);
        `CHK(intN, 1'b1)
    endtask
    // Wake needs sleep and its enable; a clear is ignored while the bus stays active.
    task automatic testWake();
        canil_host_model_i.wr(8'h2B, 8'h40);
        busActivity = 1'b1;
        tick();
        tick();
        `CHK(intN, 1'b1)
        canil_host_model_i.wr(8'h2B, 8'h00);
        sleeping = 1'b1;
        tick();
        tick();
        rdChk(8'h2C, 8'h00);
        canil_host_model_i.wr(8'h2B, 8'h40);
        tick();
        `CHK(wakeReq, 1'b1)
        `CHK(pendingSourceCode, canil_pkg::CODE_WAKE)
        canil_host_model_i.md(8'h2C, 8'h40, 8'h00);
        rdChk(8'h2C, 8'h40);
        sleeping = 1'b0;
        busActivity = 1'b0;
        canil_host_model_i.md(8'h2C, 8'h40, 8'h00);
        rdChk(8'h2C, 8'h00);
        `CHK(intN, 1'b1)
    endtask
    // Three transmit flags at once resolve by priority as each clears.
    task automatic testTxPrio();
        canil_host_model_i.wr(8'h2B, 8'h1C);
        txBufEmptyEvt = 3'h7;
        tick();
        txBufEmptyEvt = 3'h0;
        tick();
        rdChk(8'h2C, 8'h1C);
        `CHK(pendingSourceCode, canil_pkg::CODE_TX0)
        canil_host_model_i.md(8'h2C, 8'h04, 8'h00);
        `CHK(pendingSourceCode, canil_pkg::CODE_TX1)
        canil_host_model_i.md(8'h2C, 8'h08, 8'h00);
        `CHK(pendingSourceCode, canil_pkg::CODE_TX2)
        canil_host_model_i.md(8'h2C, 8'h10, 8'h00);
        `CHK(pendingSourceCode, canil_pkg::CODE_NONE)
    endtask
    // A second frame into a full buffer raises overflow and the error flag.
    task automatic testRxOvr();
        canil_host_model_i.wr(8'h2B, 8'h21);
        repeat (2) begin
            rxFrameAccepted = 2'h1;
            tick();
            rxFrameAccepted = 2'h0;
            tick();
            `CHK(rxBufFull, 2'h1)
        end
        `CHK(errorStatus, 8'h40)
        `CHK(pendingSourceCode, canil_pkg::CODE_ERR)
        canil_host_model_i.md(8'h2D, 8'h40, 8'h00);
        rdChk(8'h2D, 8'h00);
        canil_host_model_i.md(8'h2C, 8'h20, 8'h00);
        `CHK(pendingSourceCode, canil_pkg::CODE_RX0)
        canil_host_model_i.md(8'h2C, 8'h01, 8'h00);
        `CHK(intN, 1'b1)
    endtask
    // Error counts walked across the warning, passive and bus-off limits.
    task automatic setCnt(input logic [7:0] r, input logic [8:0] t, input logic [7:0] exp);
        rxErrCount = r;
        txErrCount = t;
        tick();
        tick();
        `CHK(errorStatus, exp)
    endtask
    task automatic testCounts();
        canil_host_model_i.wr(8'h2B, 8'h20);
        setCnt(8'd95, 9'd95, 8'h00);
        setCnt(8'd96, 9'd0, 8'h03);
        `CHK(intN, 1'b0)
        setCnt(8'd128, 9'd0, 8'h0B);
        setCnt(8'd0, 9'd96, 8'h05);
        setCnt(8'd0, 9'd128, 8'h15);
        setCnt(8'd0, 9'd256, 8'h35);
        setCnt(8'd0, 9'd0, 8'h20);
        busRecovered = 1'b1;
        tick();
        busRecovered = 1'b0;
        tick();
        `CHK(errorStatus, 8'h00)
        canil_host_model_i.md(8'h2C, 8'h20, 8'h00);
        `CHK(intN, 1'b1)
    endtask
    // Host-set flags interrupt only when enabled.
    task automatic testHostSet();
        canil_host_model_i.wr(8'h2B, 8'h00);
        canil_host_model_i.wr(8'h2C, 8'h02);
        `CHK(intN, 1'b1)
        canil_host_model_i.wr(8'h2B, 8'h02);
        `CHK(intN, 1'b0)
        `CHK(pendingSourceCode, canil_pkg::CODE_RX1)
        canil_host_model_i.wr(8'h2C, 8'h00);
        `CHK(intN, 1'b1)
    endtask
    // A mid-run reset returns the enable and flag registers and the pin, code, read and buffer outputs to idle.
    task automatic testReset();
        canil_host_model_i.wr(8'h2B, 8'hFF);
        canil_host_model_i.wr(8'h2C, 8'h1F);
        rdChk(8'h2C, 8'h1F);
        `CHK(intN, 1'b0)
        sys_rst = 1'b1;
        tick();
        tick();
        sys_rst = 1'b0;
        `CHK(intN, 1'b1)
        `CHK(pendingSourceCode, canil_pkg::CODE_NONE)
        `CHK(regRdData, 8'h00)
        `CHK(rxBufFull, 2'h0)
        rdChk(8'h2B, 8'h00);
        rdChk(8'h2C, 8'h00);
    endtask
    // Main sequence: five reset cycles, then every scenario.
    initial begin
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        testRegs();
        testMsgErr();
        testWake();
        testTxPrio();
        testRxOvr();
        testCounts();
        testHostSet();
        testReset();
        print_verdict();
    end
endmodule
